// ---- src/sstf_tx_framer.v ----
/*
 Transmit message framer with AXI4-Lite register slave and serial output.
 Assumes a single clock, synchronous active-low reset, a compliant master,
 and a line that samples txd once per BIT_CYCLES clocks.
*/
`timescale 1ns/1ps
`include "sstf_consts.vh"
module sstf_tx_framer #(
  parameter BIT_CYCLES = `BIT_CYCLES_DEF,
  parameter MAINT_CYCLES = `MAINT_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [`AXI_ADDR_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [`AXI_ADDR_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg txd
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;
  localparam [2:0] K_NONE = 3'h0;
  localparam [2:0] K_DATA = 3'h1;
  localparam [2:0] K_FLAG = 3'h2;
  localparam [2:0] K_SYNC = 3'h3;
  localparam [2:0] K_ABORT = 3'h4;
  localparam [2:0] K_CRC = 3'h5;

  // software-visible state, plus the internal buf_full flag that no read returns
  reg [7:0] tx_data;
  reg tx_start_of_message;
  reg tx_end_of_message;
  reg tx_abort_request;
  reg send_enable;
  reg byte_protocol_mode;
  reg [1:0] test_mode;
  reg tx_char_done;
  reg tx_active;
  reg tx_underrun_flag;
  reg maint_timer_bit;
  reg buf_full;

  // serialiser
  reg state;
  reg [15:0] shreg;
  reg [3:0] bits_left;
  reg [2:0] cur_kind;
  reg crc_sent;

  // bus slave
  reg aw_got;
  reg w_got;
  reg [`AXI_ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire bit_tick;
  wire maint_tick;
  wire [15:0] crc_value;
  wire maint_enable = test_mode[1];

  // crc presented on the line, msb first
  function [15:0] crc_present;
    input [15:0] c;
    input byte_mode;
    integer i;
    reg [15:0] p;
    begin
      p = byte_mode ? c : ~c;
      for (i = 0; i < 16; i = i + 1) begin
        crc_present[i] = p[15 - i];
      end
    end
  endfunction

  // next character chosen at each character boundary
  reg [15:0] next_char;
  reg [3:0] next_last;
  reg [2:0] next_kind;
  reg next_go;
  reg next_underrun;

  always @* begin
    next_char = {8'h00, `FLAG_CHAR};
    next_last = `CHAR_LAST;
    next_kind = K_FLAG;
    next_go = 1'b1;
    next_underrun = 1'b0;
    if (tx_abort_request) begin
      next_char = {8'h00, `ABORT_CHAR};
      next_kind = K_ABORT;
    end else if (!send_enable && !tx_end_of_message) begin
      next_go = 1'b0;
    end else if (tx_start_of_message) begin
      if (byte_protocol_mode) begin
        next_char = {8'h00, tx_data};
        next_kind = K_SYNC;
      end else begin
        next_kind = K_FLAG;
      end
    end else if (buf_full) begin
      next_char = {8'h00, tx_data};
      next_kind = K_DATA;
    end else if (tx_end_of_message && !crc_sent) begin
      next_char = crc_present(crc_value, byte_protocol_mode);
      next_last = `CRC_LAST;
      next_kind = K_CRC;
    end else if (tx_end_of_message) begin
      if (byte_protocol_mode || !send_enable) begin
        next_go = 1'b0;
      end else begin
        next_kind = K_FLAG;
      end
    end else begin
      if (byte_protocol_mode) begin
        next_char = {8'h00, tx_data};
        next_kind = K_SYNC;
      end
      next_underrun = 1'b1;
    end
  end

  // bit leaving on this tick and whether it enters the crc
  wire boundary = (bits_left == 4'h0);
  wire out_bit = boundary ? next_char[0] : shreg[0];
  wire out_feed = boundary ? (next_kind == K_DATA) : (cur_kind == K_DATA);
  wire shift_tick = bit_tick && (state == ST_SHIFT);
  wire out_valid = !boundary || next_go;
  wire start_ok = (state == ST_IDLE) && !tx_active && send_enable &&
                  (tx_start_of_message || tx_abort_request);
  wire crc_init = start_ok || tx_start_of_message;
  wire crc_shift = shift_tick && out_valid && out_feed;

  sstf_tick #(
    .DIV(BIT_CYCLES),
    .CW(16)
  ) u_bit_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(state == ST_IDLE),
    .tick(bit_tick)
  );

  sstf_tick #(
    .DIV(MAINT_CYCLES),
    .CW(24)
  ) u_maint_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(!maint_enable),
    .tick(maint_tick)
  );

  sstf_crc16 u_crc (
    .aclk(aclk),
    .aresetn(aresetn),
    .init(crc_init),
    .shift_en(crc_shift),
    .bit_in(out_bit),
    .poly(byte_protocol_mode ? `POLY_BYTE : `POLY_BIT),
    .crc(crc_value)
  );

  // bus write decode
  wire wr_fire = aw_got && w_got && !bvalid;
  wire wr_buf = wr_fire && ({aw_addr_q[`AXI_ADDR_W-1:2], 2'b00} == `OFS_BUF);
  wire wr_ctl = wr_fire && ({aw_addr_q[`AXI_ADDR_W-1:2], 2'b00} == `OFS_CTL);
  wire new_som = w_strb_q[1] ? w_data_q[`B_SOM] : tx_start_of_message;

  // write channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= {`AXI_ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_buf || wr_ctl) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
      if ({araddr[`AXI_ADDR_W-1:2], 2'b00} == `OFS_BUF) begin
        rdata[7:0] <= tx_data;
        rdata[`B_SOM] <= tx_start_of_message;
        rdata[`B_EOM] <= tx_end_of_message;
        rdata[`B_ABORT] <= tx_abort_request;
        rdata[`B_MAINT] <= maint_enable && maint_timer_bit;
        rdata[`B_CRCDIAG] <= (test_mode == `TM_INTERNAL) &&
                             (crc_value[15] == byte_protocol_mode);
      end else if ({araddr[`AXI_ADDR_W-1:2], 2'b00} == `OFS_CTL) begin
        rdata[`B_MODE] <= byte_protocol_mode;
        rdata[`B_TEST_HI:`B_TEST_LO] <= test_mode;
        rdata[`B_SEND] <= send_enable;
        rdata[`B_DONE] <= tx_char_done;
        rdata[`B_ACTIVE] <= tx_active;
        rdata[`B_UNDERRUN] <= tx_underrun_flag;
      end else begin
        rresp <= `RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // maintenance timer
  always @(posedge aclk) begin
    if (!aresetn || !maint_enable) begin
      maint_timer_bit <= 1'b0;
    end else if (maint_tick) begin
      maint_timer_bit <= !maint_timer_bit;
    end
  end

  // control registers and flags written by software
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_data <= 8'h00;
      tx_start_of_message <= 1'b0;
      tx_end_of_message <= 1'b0;
      tx_abort_request <= 1'b0;
      send_enable <= 1'b0;
      byte_protocol_mode <= 1'b0;
      test_mode <= 2'h0;
    end else begin
      if (wr_buf && w_strb_q[0]) begin
        tx_data <= w_data_q[7:0];
      end
      if (wr_buf && w_strb_q[1]) begin
        tx_start_of_message <= w_data_q[`B_SOM];
        tx_end_of_message <= w_data_q[`B_EOM];
        tx_abort_request <= w_data_q[`B_ABORT];
      end
      if (wr_ctl && w_strb_q[0]) begin
        byte_protocol_mode <= w_data_q[`B_MODE];
        test_mode <= w_data_q[`B_TEST_HI:`B_TEST_LO];
        send_enable <= w_data_q[`B_SEND];
      end
    end
  end

  // serialiser and hardware status
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      txd <= 1'b1;
      shreg <= 16'h0000;
      bits_left <= 4'h0;
      cur_kind <= K_NONE;
      crc_sent <= 1'b0;
      tx_active <= 1'b0;
      buf_full <= 1'b0;
      tx_char_done <= 1'b0;
      tx_underrun_flag <= 1'b0;
    end else begin
      if (wr_buf && w_strb_q[0]) begin
        tx_char_done <= 1'b0;
      end
      if (wr_buf && w_strb_q[1] && w_data_q[`B_SOM]) begin
        tx_underrun_flag <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          txd <= 1'b1;
          if (start_ok) begin
            state <= ST_SHIFT;
            tx_active <= 1'b1;
            bits_left <= 4'h0;
            cur_kind <= K_NONE;
            crc_sent <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (bit_tick && !boundary) begin
            txd <= shreg[0];
            shreg <= {1'b0, shreg[15:1]};
            bits_left <= bits_left - 1'b1;
          end else if (bit_tick) begin
            if (cur_kind == K_FLAG || cur_kind == K_SYNC ||
                cur_kind == K_ABORT || cur_kind == K_DATA) begin
              tx_char_done <= 1'b1;
            end
            if (next_go) begin
              txd <= next_char[0];
              shreg <= {1'b0, next_char[15:1]};
              bits_left <= next_last;
              cur_kind <= next_kind;
              if (next_kind == K_DATA) begin
                buf_full <= 1'b0;
                crc_sent <= 1'b0;
              end
              if (next_kind == K_CRC) begin
                crc_sent <= 1'b1;
              end
              if (next_underrun) begin
                tx_underrun_flag <= 1'b1;
              end
            end else begin
              state <= ST_IDLE;
              tx_active <= 1'b0;
              txd <= 1'b1;
              cur_kind <= K_NONE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          tx_active <= 1'b0;
        end
      endcase
      if (wr_buf && w_strb_q[0]) begin
        buf_full <= !new_som;
      end
    end
  end
endmodule // sstf_tx_framer

// ---- inc/sstf_consts.vh ----
/*
 Constants for the synchronous serial transmit framer: register map,
 field positions, reset values, line characters, CRC polynomials, timing.
 Assumes a 100 MHz aclk and a 32-bit AXI4-Lite master.
*/
`ifndef SSTF_CONSTS_VH
`define SSTF_CONSTS_VH

`define AXI_ADDR_W 8
`define OFS_BUF 8'h00
`define OFS_CTL 8'h04
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define B_SOM 8
`define B_EOM 9
`define B_ABORT 10
`define B_MAINT 11
`define B_CRCDIAG 12
`define B_MODE 0
`define B_TEST_LO 1
`define B_TEST_HI 2
`define B_SEND 4
`define B_DONE 7
`define B_ACTIVE 8
`define B_UNDERRUN 9

`define TM_INTERNAL 2'h1
`define FLAG_CHAR 8'h7E
`define ABORT_CHAR 8'hFF
`define CHAR_LAST 4'h7
`define CRC_LAST 4'hF
`define CRC_INIT 16'h0000
`define POLY_BYTE 16'h8005
`define POLY_BIT 16'h1021

`define CLK_PERIOD_NS 10
`define MAINT_PERIOD_NS 100000
`define BIT_CYCLES_DEF 16

`endif

// ---- src/sstf_tick.v ----
/*
 Periodic one-cycle tick generator.
 Assumes hold is a synchronous level; DIV is at least 2.
*/
`timescale 1ns/1ps
module sstf_tick #(
  parameter DIV = 16,
  parameter CW = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire hold,
  output reg tick
);
  localparam [31:0] LAST_W = DIV - 1;
  localparam [CW-1:0] LAST = LAST_W[CW-1:0];
  reg [CW-1:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn || hold) begin
      cnt <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // sstf_tick

// ---- src/sstf_crc16.v ----
/*
 Serial 16-bit CRC register, msb feedback, selectable polynomial.
 Assumes one bit per shift_en; init has priority over shifting.
*/
`timescale 1ns/1ps
`include "sstf_consts.vh"
module sstf_crc16 (
  input wire aclk,
  input wire aresetn,
  input wire init,
  input wire shift_en,
  input wire bit_in,
  input wire [15:0] poly,
  output reg [15:0] crc
);
  always @(posedge aclk) begin
    if (!aresetn || init) begin
      crc <= `CRC_INIT;
    end else if (shift_en) begin
      crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ bit_in) ? poly : 16'h0000);
    end
  end
endmodule // sstf_crc16

// ---- verif/sstf_line_rx.sv ----
/* line partner: hunts the first space after arm, then frames bytes lsb first.
   assumes txd is held BIT_CYCLES clocks per bit */
`timescale 1ns/1ps
module sstf_line_rx #(
  parameter BIT_CYCLES = 4
) (
  input wire aclk,
  input wire arm,
  input wire txd,
  output reg [7:0] rx_byte,
  output reg rx_stb
);
  reg sync = 1'b0;
  reg [7:0] sh = 8'h00;
  integer cnt = 0;
  integer nb = 0;
  always @(posedge aclk) begin
    rx_stb <= 1'b0;
    if (!arm) begin
      sync <= 1'b0;
    end else if (!sync ? !txd : cnt == 0) begin
      sync <= 1'b1;
      cnt <= BIT_CYCLES - 1;
      sh <= {txd, sh[7:1]};
      if (sync && nb == 7) begin
        nb <= 0;
        rx_byte <= {txd, sh[7:1]};
        rx_stb <= 1'b1;
      end else begin
        nb <= sync ? nb + 1 : 1;
      end
    end else begin
      cnt <= cnt - 1;
    end
  end
endmodule // sstf_line_rx

// ---- verif/sstf_chk_sva.sv ----
/* checker: bus handshake timing, reset state, bit width on txd.
   assumes it sees the framer top ports only */
`timescale 1ns/1ps
`include "sstf_consts.vh"
module sstf_chk #(
  parameter BIT_CYCLES = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [`AXI_ADDR_W-1:0] awaddr,
  input wire awvalid,
  input wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [`AXI_ADDR_W-1:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  input wire txd
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [7:0] run;
  always @(posedge aclk) begin
    if (!aresetn) run <= 8'hFF;
    else if ($changed(txd)) run <= 8'h00;
    else if (run != 8'hFF) run <= run + 8'h01;
  end
  chk_b_latency: assert property (awvalid && awready && wvalid && wready |-> ##1 !bvalid ##1 bvalid)
    else $error("write answer not two edges after take");
  chk_b_readies: assert property (bvalid |-> !awready && !wready)
    else $error("write ready while answer pending");
  chk_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write answer not released");
  chk_r_latency: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one edge after take");
  chk_r_release: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read answer not released");
  chk_r_unmapped: assert property (arvalid && arready && araddr >= 8'h08 |=>
    rresp == `RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
  chk_reset_mark: assert property (disable iff (1'b0) !aresetn |=> txd && !bvalid && !rvalid)
    else $error("reset state wrong");
  chk_bit_width: assert property ($changed(txd) |-> run >= BIT_CYCLES - 1)
    else $error("line bit shorter than bit time");
  cover property ($fell(txd));
  cover property (bvalid && bresp == `RESP_SLVERR);
  cover property (rvalid && rdata[8]);
endmodule // sstf_chk

// ---- verif/test_sync_serial_tx_message_framing.sv ----
/* top bench: bus tasks, line partner, checker bind.
   assumes 100 MHz aclk and short bit and timer counts */
`timescale 1ns/1ps
`include "sstf_consts.vh"
module test_sync_serial_tx_message_framing;
  localparam BC = 4;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, b;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, arm = 1'b0;
  reg [31:0] wdata = 32'h0, rv, m1;
  reg [3:0] wstrb = 4'h0;
  wire awready, wready, bvalid, arready, rvalid, txd, rx_stb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] rx_byte;
  integer n_mismatch = 0, comparisons = 0, n, cyc = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  sstf_tx_framer #(.BIT_CYCLES(BC), .MAINT_CYCLES(20)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .txd(txd));
  sstf_line_rx #(.BIT_CYCLES(BC)) line (.aclk(aclk), .arm(arm), .txd(txd), .rx_byte(rx_byte),
    .rx_stb(rx_stb));
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (!bvalid) begin
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        @(posedge aclk);
      end
      chk("bresp", er, bresp);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] ev, input [1:0] er);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!rvalid) begin
        if (arready) arvalid <= 1'b0;
        @(posedge aclk);
      end
      rv = rdata;
      chk("rresp", er, rresp);
      chk("rdata", ev, rdata & m);
      rready <= 1'b0;
    end
  endtask
  task getb;
    begin
      @(posedge aclk);
      while (!rx_stb) @(posedge aclk);
      b = rx_byte;
    end
  endtask
  task skip(input [7:0] x);
    begin
      getb;
      while (b === x) getb;
    end
  endtask
  task tdone(input [8*6-1:0] nm);
    $display("test %0s done", nm);
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_BUF, 32'hFFFF, 32'h0, `RESP_OKAY);
    rd(`OFS_CTL, 32'hFFFF, 32'h0, `RESP_OKAY);
    wr(`OFS_BUF, 32'h7A5, 4'h3, `RESP_OKAY);
    rd(`OFS_BUF, 32'h7FF, 32'h7A5, `RESP_OKAY);
    chk("txd", 32'h1, {31'h0, txd});
    wr(`OFS_BUF, 32'h0, 4'h2, `RESP_OKAY);
    wr(8'h10, 32'h1, 4'hF, `RESP_SLVERR);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    tdone("regs");
    wr(`OFS_CTL, 32'h2, 4'h1, `RESP_OKAY);
    rd(`OFS_BUF, 32'h1000, 32'h1000, `RESP_OKAY);
    wr(`OFS_CTL, 32'h3, 4'h1, `RESP_OKAY);
    rd(`OFS_BUF, 32'h1000, 32'h0, `RESP_OKAY);
    tdone("crcpol");
    wr(`OFS_CTL, 32'h4, 4'h1, `RESP_OKAY);
    n = cyc;
    rd(`OFS_BUF, 32'hFFFFF7FF, 32'hA5, `RESP_OKAY);
    m1 = rv;
    while (cyc != n + 20) @(posedge aclk);
    rd(`OFS_BUF, 32'h800, ~m1 & 32'h800, `RESP_OKAY);
    wr(`OFS_CTL, 32'h0, 4'h1, `RESP_OKAY);
    rd(`OFS_BUF, 32'h800, 32'h0, `RESP_OKAY);
    tdone("maint");
    arm <= 1'b1;
    wr(`OFS_CTL, 32'h10, 4'h1, `RESP_OKAY);
    wr(`OFS_BUF, 32'h100, 4'h2, `RESP_OKAY);
    n = 0;
    while (txd) begin
      @(posedge aclk);
      n = n + 1;
    end
    chk("first", 32'h1, {31'h0, n <= 2 * BC});
    getb;
    chk("flag", 32'h7E, {24'h0, b});
    repeat (BC) @(posedge aclk);
    rd(`OFS_CTL, 32'h390, 32'h190, `RESP_OKAY);
    wr(`OFS_BUF, 32'h2A5, 4'h3, `RESP_OKAY);
    skip(8'h7E);
    chk("data", 32'hA5, {24'h0, b});
    getb;
    getb;
    getb;
    chk("idle", 32'h7E, {24'h0, b});
    wr(`OFS_BUF, 32'h0C3, 4'h3, `RESP_OKAY);
    skip(8'h7E);
    chk("data", 32'hC3, {24'h0, b});
    getb;
    rd(`OFS_CTL, 32'h200, 32'h200, `RESP_OKAY);
    tdone("bitmod");
    wr(`OFS_BUF, 32'h400, 4'h2, `RESP_OKAY);
    skip(8'h7E);
    chk("abort", 32'hFF, {24'h0, b});
    rd(`OFS_CTL, 32'h80, 32'h80, `RESP_OKAY);
    wr(`OFS_CTL, 32'h0, 4'h1, `RESP_OKAY);
    wr(`OFS_BUF, 32'h0, 4'h2, `RESP_OKAY);
    arm <= 1'b0;
    repeat (16 * BC) @(posedge aclk);
    chk("txd", 32'h1, {31'h0, txd});
    tdone("abort");
    wr(`OFS_CTL, 32'h10, 4'h1, `RESP_OKAY);
    arm <= 1'b1;
    wr(`OFS_BUF, 32'h100, 4'h2, `RESP_OKAY);
    getb;
    chk("flag", 32'h7E, {24'h0, b});
    wr(`OFS_BUF, 32'h25A, 4'h3, `RESP_OKAY);
    wr(`OFS_CTL, 32'h0, 4'h1, `RESP_OKAY);
    skip(8'h7E);
    chk("data", 32'h5A, {24'h0, b});
    repeat (24 * BC) @(posedge aclk);
    rd(`OFS_CTL, 32'h110, 32'h0, `RESP_OKAY);
    arm <= 1'b0;
    tdone("eomend");
    wr(`OFS_CTL, 32'h11, 4'h1, `RESP_OKAY);
    arm <= 1'b1;
    wr(`OFS_BUF, 32'h196, 4'h3, `RESP_OKAY);
    getb;
    chk("sync", 32'h96, {24'h0, b});
    rd(`OFS_CTL, 32'h200, 32'h0, `RESP_OKAY);
    getb;
    chk("sync", 32'h96, {24'h0, b});
    wr(`OFS_BUF, 32'h23C, 4'h3, `RESP_OKAY);
    skip(8'h96);
    chk("data", 32'h3C, {24'h0, b});
    repeat (24 * BC) @(posedge aclk);
    rd(`OFS_CTL, 32'h100, 32'h0, `RESP_OKAY);
    chk("txd", 32'h1, {31'h0, txd});
    tdone("bytmod");
    tally_and_finish;
  end
endmodule // test_sync_serial_tx_message_framing
bind sstf_tx_framer sstf_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_i (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .txd(txd));
